// *** design/vec_irq_defines.svh ***
`ifndef VEC_IRQ_DEFINES_SVH
`define VEC_IRQ_DEFINES_SVH

// Register addresses on the plain register port.
`define CORE_CTRL_ADDR   8'h35
`define IRQ_ENABLE_ADDR  8'h3B
`define IRQ_FLAG_ADDR    8'h3A
`define PC_MASK_ADDR     8'h15

// Field positions inside the registers.
`define SENSE_HI_BIT     1
`define SENSE_LO_BIT     0
`define EXT_EN_BIT       6
`define PC_EN_BIT        5
`define EXT_FLAG_BIT     6
`define PC_FLAG_BIT      5
`define PC_MASK_MSB      5

// Reset values.
`define SENSE_RESET      2'h0
`define MASK_RESET       6'h00
`define DATA_ZERO        8'h00

// Sense-select encodings for the external pin.
`define SENSE_LOW        2'h0
`define SENSE_ANY        2'h1
`define SENSE_FALL       2'h2
`define SENSE_RISE       2'h3

// Vector program addresses, one per source.
`define VEC_RESET        4'h0
`define VEC_EXT          4'h1
`define VEC_PC           4'h2
`define VEC_T1_CMPA      4'h3
`define VEC_T1_OVF       4'h4
`define VEC_T0_OVF       4'h5
`define VEC_MEM_RDY      4'h6
`define VEC_ACOMP        4'h7
`define VEC_CONV         4'h8
`define VEC_T1_CMPB      4'h9
`define VEC_T0_CMPA      4'hA
`define VEC_T0_CMPB      4'hB
`define VEC_WDT          4'hC
`define VEC_SER_START    4'hD
`define VEC_SER_OVF      4'hE
`define VEC_PERIPH_FIRST 4'h3
`define VEC_LAST         4'hE
`define VEC_COUNT        15
`define PERIPH_COUNT     12

// Cycles after reset before the synchronised pins are trusted for edges.
`define PRIME_CYCLES     2'h3
`define PRIME_RESET      2'h0

`endif

// *** design/vec_irq_pkg.sv ***
package vec_irq_pkg;

  typedef logic [7:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef logic [3:0] vec_addr_t;
  typedef logic [1:0] sense_t;
  typedef logic [5:0] pc_bits_t;
  typedef logic [11:0] periph_bits_t;

endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin levels; the first stage feeds only the second.
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_reg;

  // Data path only, so no reset: the main block ignores edges until it is primed.
  always_ff @(posedge clock) begin
    meta_reg <= pin_in;
    pin_out  <= meta_reg;
  end

endmodule

`default_nettype wire

// *** design/vector_and_external_irq.sv ***
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "vec_irq_defines.svh"

// Function
// - All resets start at vector address zero.
// - External pin vector 1, pin change 2.
// - Timer sources at addresses three to five.
// - Timer compare B and timer zero compares: 9-B.
// - Fifteen vectors, remaining peripherals mapped in order.
// - Interrupts fire even when pins drive outputs.
// - Any unmasked pin-change toggle raises shared request.
// - Pin-change detection needs no I/O clock.
// - External pin senses fall, rise or low.
// - Low level requests while pin stays low.
// - Edges recognised only while I/O clock runs.
// - Low level detected without the I/O clock.
// - Sleep beyond idle stops edge detection.
// - Vanished low level gives no interrupt.
// - Sense codes: low, change, fall, rise.
// - External flag: set on edge, cleared, level-clear.
// - Pin-change flag: set on change, clearable.
// - Per-pin mask plus global pin-change enable.
module vector_and_external_irq (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire vec_irq_pkg::reg_addr_t    bus_addr,
  input  wire vec_irq_pkg::reg_data_t    bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output var  vec_irq_pkg::reg_data_t    bus_rdata,
  input  wire logic                      ext_irq_pin,
  input  wire vec_irq_pkg::pc_bits_t     pin_change_inputs,
  input  wire logic                      io_clock_run,
  input  wire logic                      global_irq_enable,
  input  wire vec_irq_pkg::periph_bits_t periph_irq,
  input  wire logic                      core_ack,
  input  wire vec_irq_pkg::vec_addr_t    core_ack_addr,
  output var  logic                      irq_req,
  output var  vec_irq_pkg::vec_addr_t    irq_addr,
  output var  logic                      wake_req
);

  import vec_irq_pkg::*;

  // Synchronised pin levels, their one-cycle-old copies and the priming count.
  logic                   ext_now;
  pc_bits_t               pc_now;
  logic                   ext_prev_reg;
  pc_bits_t               pc_prev_reg;
  logic [1:0]             prime_cnt_reg;
  logic                   primed;

  // Software-visible control and status.
  sense_t                 sense_reg;
  logic                   ext_en_reg;
  logic                   pc_en_reg;
  pc_bits_t               pin_change_mask;
  logic                   ext_irq_flag;
  logic                   change_irq_flag;

  // Detection and arbitration terms.
  logic                   ext_fall;
  logic                   ext_rise;
  logic                   ext_edge_hit;
  logic                   level_mode;
  logic                   ext_low_req;
  logic                   pc_change;
  logic [`VEC_COUNT-1:0]  pend;
  vec_addr_t              sel_addr;
  logic                   sel_hit;
  logic                   wr_flag;
  logic                   ack_ext;
  logic                   ack_pc;

  // Output registers.
  reg_data_t              rdata_reg;
  reg_data_t              rdata_next;
  logic                   irq_req_reg;
  vec_addr_t              irq_addr_reg;
  logic                   wake_req_reg;

  // The pad input is sampled after the output driver, so a pin that software
  // drives as an output still reaches the detectors below.
  pin_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .clock   (clock),
    .pin_in  ({ext_irq_pin, pin_change_inputs}),
    .pin_out ({ext_now, pc_now})
  );

  // Previous pin levels, tracked even while the I/O clock is stopped so that
  // a change made during sleep is not seen as an edge on resume.
  always_ff @(posedge clock) begin
    ext_prev_reg <= ext_now;
    pc_prev_reg  <= pc_now;
  end

  // The synchroniser holds no reset value, so edges are ignored until both
  // stages and the previous copy carry real pin levels.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prime_cnt_reg <= `PRIME_RESET;
    end else if (!primed) begin
      prime_cnt_reg <= prime_cnt_reg + 2'h1;
    end
  end

  assign primed = (prime_cnt_reg == `PRIME_CYCLES);

  // Edge recognition on the external pin needs the I/O clock; in every sleep
  // mode deeper than idle it is stopped and edges pass unseen.
  assign ext_fall = primed && io_clock_run && ext_prev_reg && !ext_now;
  assign ext_rise = primed && io_clock_run && !ext_prev_reg && ext_now;

  // Sense-select decoding for the external pin.
  always_comb begin
    case (sense_reg)
      `SENSE_LOW:  ext_edge_hit = 1'b0;
      `SENSE_ANY:  ext_edge_hit = ext_fall || ext_rise;
      `SENSE_FALL: ext_edge_hit = ext_fall;
      `SENSE_RISE: ext_edge_hit = ext_rise;
      default:     ext_edge_hit = 1'b0;
    endcase
  end

  // Low level is a live condition, not latched, so it needs no I/O clock and
  // disappears as soon as the pin rises; a level that drops before wake-up
  // completes leaves nothing pending and the core just resumes.
  assign level_mode  = (sense_reg == `SENSE_LOW);
  assign ext_low_req = level_mode && ext_en_reg && !ext_now;

  // Pin-change detection runs off the always-on clock, not the I/O clock;
  // only pins with their mask bit set take part.
  assign pc_change = primed && (|((pc_prev_reg ^ pc_now) & pin_change_mask));

  // Hardware clear by the core when it takes a vector, and software clear by a flag write.
  assign ack_ext = core_ack && (core_ack_addr == `VEC_EXT);
  assign ack_pc  = core_ack && (core_ack_addr == `VEC_PC);
  assign wr_flag = bus_wr && (bus_addr == `IRQ_FLAG_ADDR);

  // External flag: a new edge wins over a clear in the same cycle, and the
  // flag is held clear while the pin is in level mode.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_irq_flag <= 1'b0;
    end else if (ext_edge_hit) begin
      ext_irq_flag <= 1'b1;
    end else if (level_mode || ack_ext || (wr_flag && bus_wdata[`EXT_FLAG_BIT])) begin
      ext_irq_flag <= 1'b0;
    end
  end

  // Pin-change flag follows the same set-over-clear priority.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      change_irq_flag <= 1'b0;
    end else if (pc_change) begin
      change_irq_flag <= 1'b1;
    end else if (ack_pc || (wr_flag && bus_wdata[`PC_FLAG_BIT])) begin
      change_irq_flag <= 1'b0;
    end
  end

  // Sense-select bits of the core control register.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sense_reg <= `SENSE_RESET;
    end else if (bus_wr && (bus_addr == `CORE_CTRL_ADDR)) begin
      sense_reg <= {bus_wdata[`SENSE_HI_BIT], bus_wdata[`SENSE_LO_BIT]};
    end
  end

  // Source enables for the external pin and the shared pin-change request.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_en_reg <= 1'b0;
      pc_en_reg  <= 1'b0;
    end else if (bus_wr && (bus_addr == `IRQ_ENABLE_ADDR)) begin
      ext_en_reg <= bus_wdata[`EXT_EN_BIT];
      pc_en_reg  <= bus_wdata[`PC_EN_BIT];
    end
  end

  // Per-pin change mask.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_change_mask <= `MASK_RESET;
    end else if (bus_wr && (bus_addr == `PC_MASK_ADDR)) begin
      pin_change_mask <= bus_wdata[`PC_MASK_MSB:0];
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_next = `DATA_ZERO;
    case (bus_addr)
      `CORE_CTRL_ADDR: begin
        rdata_next[`SENSE_HI_BIT] = sense_reg[1];
        rdata_next[`SENSE_LO_BIT] = sense_reg[0];
      end
      `IRQ_ENABLE_ADDR: begin
        rdata_next[`EXT_EN_BIT] = ext_en_reg;
        rdata_next[`PC_EN_BIT]  = pc_en_reg;
      end
      `IRQ_FLAG_ADDR: begin
        rdata_next[`EXT_FLAG_BIT] = ext_irq_flag;
        rdata_next[`PC_FLAG_BIT]  = change_irq_flag;
      end
      `PC_MASK_ADDR: begin
        rdata_next[`PC_MASK_MSB:0] = pin_change_mask;
      end
      default: begin
        rdata_next = `DATA_ZERO;
      end
    endcase
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= `DATA_ZERO;
    end else if (bus_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `DATA_ZERO;
    end
  end

  // Pending requests indexed by vector address; address zero belongs to the
  // reset entry and never pends. Peripheral bit k sits at address k + 3:
  // timer one compare A, timer one overflow, timer zero overflow, memory
  // write ready, comparator, converter, timer one compare B, timer zero
  // compares A and B, watchdog, serial start and serial overflow.
  always_comb begin
    pend                                  = '0;
    pend[`VEC_EXT]                        = ext_en_reg && (level_mode ? ext_low_req
                                                                     : ext_irq_flag);
    pend[`VEC_PC]                         = pc_en_reg && change_irq_flag;
    pend[`VEC_LAST:`VEC_PERIPH_FIRST]     = periph_irq;
  end

  // Fixed priority: the scan runs downward so the lowest number wins.
  always_comb begin
    sel_addr = `VEC_RESET;
    sel_hit  = 1'b0;
    for (int i = `VEC_COUNT - 1; i >= 1; i--) begin
      if (pend[i]) begin
        sel_addr = 4'(i);
        sel_hit  = 1'b1;
      end
    end
  end

  // Vector presented to the core. The cycle of an acknowledge drops the
  // request so the core never sees a source it has just cleared.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_req_reg  <= 1'b0;
      irq_addr_reg <= `VEC_RESET;
    end else begin
      irq_req_reg  <= sel_hit && global_irq_enable && !core_ack;
      irq_addr_reg <= sel_hit ? sel_addr : `VEC_RESET;
    end
  end

  // Wake-up asks only for the asynchronous sources; an edge-mode external
  // request cannot appear while the I/O clock is stopped anyway.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= pend[`VEC_EXT] || pend[`VEC_PC];
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq_req   = irq_req_reg;
  assign irq_addr  = irq_addr_reg;
  assign wake_req  = wake_req_reg;

  // The checks below watch only this block's inputs, its state and the outputs that it drives.
  // A falling edge seen over two cycles with the I/O clock running.
  sequence ext_fall_s;
    primed && io_clock_run && (sense_reg == `SENSE_FALL) && ext_now
    ##1 io_clock_run && (sense_reg == `SENSE_FALL) && !ext_now;
  endsequence

  // A masked pin toggle seen over two cycles.
  sequence pc_toggle_s;
    primed ##1 (|((pc_prev_reg ^ pc_now) & pin_change_mask));
  endsequence

  reset_vector_a: assert property (@(posedge clock)
    sys_rst |=> (irq_addr_reg == `VEC_RESET) && !irq_req_reg)
    else $error("reset does not present vector zero");

  fall_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    ext_fall_s |=> ext_irq_flag)
    else $error("falling edge did not set the external flag");

  level_request_a: assert property (@(posedge clock) disable iff (sys_rst)
    (level_mode && ext_en_reg && !ext_now && global_irq_enable && !core_ack)
    |=> irq_req_reg && (irq_addr_reg == `VEC_EXT))
    else $error("low level did not request the external vector");

  level_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    level_mode |=> !ext_irq_flag)
    else $error("external flag set while in level mode");

  edge_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!io_clock_run && !ext_irq_flag) |=> !ext_irq_flag)
    else $error("edge recognised without the I/O clock");

  pc_toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
    pc_toggle_s |=> change_irq_flag)
    else $error("masked pin change did not set the flag");

  pc_masked_a: assert property (@(posedge clock) disable iff (sys_rst)
    ((pin_change_mask == `MASK_RESET) && !change_irq_flag) |=> !change_irq_flag)
    else $error("masked-off pin set the change flag");

  pc_sleep_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!io_clock_run && pc_change) |=> change_irq_flag)
    else $error("pin change lost while the I/O clock is stopped");

  ack_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ack_pc && !pc_change) |=> !change_irq_flag)
    else $error("acknowledge did not clear the change flag");

  lowest_first_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pend[`VEC_PC] && !pend[`VEC_EXT] && global_irq_enable && !core_ack)
    |=> irq_req_reg && (irq_addr_reg == `VEC_PC))
    else $error("pin-change vector not chosen over peripherals");

endmodule

`default_nettype wire

// *** test/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behavioural core that takes the pending vector after a chosen wait.
module core_model (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   enable,
  input  wire logic [3:0]             ack_delay,
  input  wire logic                   irq_req,
  input  wire vec_irq_pkg::vec_addr_t irq_addr,
  output var  logic                   core_ack,
  output var  vec_irq_pkg::vec_addr_t core_ack_addr
);
  import vec_irq_pkg::*;

  logic [3:0] wait_count = 4'h0;

  initial core_ack = 1'b0;
  initial core_ack_addr = 4'h0;

  // The ack is one cycle; the address wanders between acks so a stale value is never read.
  always @(posedge clock) begin
    if (sys_rst || !enable || !irq_req || core_ack) begin
      core_ack <= 1'b0;
      core_ack_addr <= ~core_ack_addr;
      wait_count <= 4'h0;
    end else if (wait_count >= ack_delay) begin
      core_ack <= 1'b1;
      core_ack_addr <= irq_addr;
      wait_count <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      core_ack_addr <= ~core_ack_addr;
      wait_count <= wait_count + 4'h1;
    end
  end
endmodule

`default_nettype wire

// *** test/vector_and_external_irq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "vec_irq_defines.svh"

module vector_and_external_irq_bench;
  import vec_irq_pkg::*;

  logic         clock             = 1'b0;
  logic         sys_rst           = 1'b1;
  reg_addr_t    bus_addr          = 8'h00;
  reg_data_t    bus_wdata         = 8'h00;
  logic         bus_wr            = 1'b0;
  logic         bus_rd            = 1'b0;
  reg_data_t    bus_rdata;
  logic         ext_irq_pin       = 1'b1;
  pc_bits_t     pin_change_inputs = 6'h00;
  logic         io_clock_run      = 1'b1;
  logic         global_irq_enable = 1'b1;
  periph_bits_t periph_irq        = 12'h000;
  logic         core_ack;
  vec_addr_t    core_ack_addr;
  logic         irq_req;
  vec_addr_t    irq_addr;
  logic         wake_req;
  logic         core_enable       = 1'b0;
  int           fail_count        = 0;
  int           samples_checked   = 0;
  reg_data_t    d;

  // Single-request cases, then two two-request priority cases: peripheral request pattern beside the vector it must present.
  periph_bits_t periph_row [14] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020,
    12'h040, 12'h080, 12'h100, 12'h200, 12'h400, 12'h800, 12'hC00, 12'h840};
  vec_addr_t    vec_row [14]    = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB,
    4'hC, 4'hD, 4'hE, 4'hD, 4'h9};
  // Sense code, new pin level, I/O clock running, expected flag register.
  sense_t       sense_row [7]   = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
  logic         pin_row [7]     = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic         run_row [7]     = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  reg_data_t    flag_row [7]    = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00};
  reg_addr_t    reg_list [5]    = '{`CORE_CTRL_ADDR, `IRQ_ENABLE_ADDR, `IRQ_FLAG_ADDR,
    `PC_MASK_ADDR, 8'h20};

  always #2.5 clock = ~clock;

  vector_and_external_irq i_vector_and_external_irq (
    .clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_irq_pin(ext_irq_pin),
    .pin_change_inputs(pin_change_inputs), .io_clock_run(io_clock_run),
    .global_irq_enable(global_irq_enable), .periph_irq(periph_irq), .core_ack(core_ack),
    .core_ack_addr(core_ack_addr), .irq_req(irq_req), .irq_addr(irq_addr),
    .wake_req(wake_req));

  core_model i_core_model (
    .clock(clock), .sys_rst(sys_rst), .enable(core_enable), .ack_delay(4'h2),
    .irq_req(irq_req), .irq_addr(irq_addr), .core_ack(core_ack),
    .core_ack_addr(core_ack_addr));

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      fail_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic bus_write(input reg_addr_t addr, input reg_data_t data);
    @(posedge clock);
    bus_addr <= addr;
    bus_wdata <= data;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic bus_read(input reg_addr_t addr, output reg_data_t data);
    @(posedge clock);
    bus_addr <= addr;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 data = bus_rdata;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_ack(input vec_addr_t expected);
    int n;
    n = 0;
    cycles(1);
    while (core_ack !== 1'b1 && n < 20) begin
      cycles(1);
      n++;
    end
    check({7'h0, core_ack}, 8'h01);
    check({4'h0, core_ack_addr}, {4'h0, expected});
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The tests need well under a thousand cycles; this limit allows about four thousand.
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end

  initial begin
    cycles(3);
    check({4'h0, irq_addr}, 8'h00);
    @(posedge clock);
    sys_rst <= 1'b0;
    cycles(5);
    foreach (reg_list[i]) begin
      bus_read(reg_list[i], d);
      check(d, 8'h00);
    end
    $display("test reset done");
    foreach (periph_row[i]) begin
      @(posedge clock);
      periph_irq <= periph_row[i];
      cycles(3);
      check({7'h0, irq_req}, 8'h01);
      check({4'h0, irq_addr}, {4'h0, vec_row[i]});
    end
    @(posedge clock);
    periph_irq <= 12'h000;
    $display("test vector map done");
    // Pin change with the I/O clock stopped; only pin 2 is unmasked.
    io_clock_run <= 1'b0;
    bus_write(`PC_MASK_ADDR, 8'h04);
    bus_write(`IRQ_ENABLE_ADDR, 8'h20);
    @(posedge clock);
    pin_change_inputs <= 6'h01;
    cycles(6);
    check({7'h0, wake_req}, 8'h00);
    bus_read(`IRQ_FLAG_ADDR, d);
    check(d, 8'h00);
    @(posedge clock);
    pin_change_inputs <= 6'h05;
    cycles(6);
    check({7'h0, wake_req}, 8'h01);
    check({4'h0, irq_addr}, 8'h02);
    bus_read(`IRQ_FLAG_ADDR, d);
    check(d, 8'h20);
    bus_write(`IRQ_FLAG_ADDR, 8'h20);
    bus_read(`IRQ_FLAG_ADDR, d);
    check(d, 8'h00);
    check({7'h0, irq_req}, 8'h00);
    $display("test pin change done");
    @(posedge clock);
    io_clock_run <= 1'b1;
    bus_write(`IRQ_ENABLE_ADDR, 8'h40);
    foreach (sense_row[i]) begin
      bus_write(`CORE_CTRL_ADDR, {6'h00, sense_row[i]});
      @(posedge clock);
      ext_irq_pin <= pin_row[i];
      io_clock_run <= run_row[i];
      cycles(6);
      bus_read(`IRQ_FLAG_ADDR, d);
      check(d, flag_row[i]);
      bus_write(`IRQ_FLAG_ADDR, 8'h60);
    end
    $display("test edge modes done");
    // Level mode with the pin already low and the I/O clock stopped.
    bus_write(`CORE_CTRL_ADDR, 8'h00);
    cycles(8); // The source keeps the pin low well past wake-up
    check({7'h0, irq_req}, 8'h01);
    check({4'h0, irq_addr}, 8'h01);
    bus_read(`IRQ_FLAG_ADDR, d);
    check(d, 8'h00);
    // Global enable low: no request to the core, but wake-up and vector still stand.
    @(posedge clock);
    global_irq_enable <= 1'b0;
    cycles(2);
    check({7'h0, irq_req}, 8'h00);
    check({7'h0, wake_req}, 8'h01);
    check({4'h0, irq_addr}, 8'h01);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    @(posedge clock);
    ext_irq_pin <= 1'b1;
    cycles(5);
    check({7'h0, irq_req}, 8'h00);
    $display("test level mode done");
    // Both sources pending together, then the core takes them one by one.
    @(posedge clock);
    io_clock_run <= 1'b1;
    bus_write(`CORE_CTRL_ADDR, 8'h02);
    bus_write(`IRQ_ENABLE_ADDR, 8'h60);
    @(posedge clock);
    ext_irq_pin <= 1'b0;
    pin_change_inputs <= 6'h01;
    cycles(6);
    check({4'h0, irq_addr}, 8'h01);
    @(posedge clock);
    core_enable <= 1'b1;
    wait_ack(4'h1);
    wait_ack(4'h2);
    cycles(4);
    check({7'h0, irq_req}, 8'h00);
    bus_read(`IRQ_FLAG_ADDR, d);
    check(d, 8'h00);
    $display("test priority done");
    // A second reset in mid-run falls back to the reset vector.
    @(posedge clock);
    core_enable <= 1'b0;
    periph_irq <= 12'h001;
    cycles(3);
    @(posedge clock);
    sys_rst <= 1'b1;
    cycles(2);
    check({4'h0, irq_addr}, 8'h00);
    check({7'h0, irq_req}, 8'h00);
    // Release again: the pending peripheral returns and control is back at reset values.
    @(posedge clock);
    sys_rst <= 1'b0;
    cycles(2);
    check({7'h0, irq_req}, 8'h01);
    check({4'h0, irq_addr}, 8'h03);
    bus_read(`CORE_CTRL_ADDR, d);
    check(d, 8'h00);
    $display("test second reset done");
    complete_run();
  end
endmodule

`default_nettype wire
